// File: design/bvs_pkg.sv
// package: constants and carrier types of the bitplane video sequencer
package bvs_pkg;
	localparam int PIX_W = 8; // intensity width, red channel only
	localparam int FRAME_PIX = 16; // pixels per frame bank
	localparam int MAX_PLANES = 8; // most planes per frame
	localparam int HS_W = 4; // pixels per high speed beat
	localparam int LOAD_BEATS = FRAME_PIX / HS_W; // beats per plane load
	localparam int LANE_W = 6; // bits per serial lane
	localparam int LINK_W = 24; // parallel and serial pixel width
	localparam int RED_LANES = 2; // logical lanes holding red bits
	localparam int PMAP_W = 5; // parallel bit selector width
	localparam int TBL_BYTES = 41; // sequence table size in bytes
	localparam int TBL_PLANE_OFF = 1; // first plane entry byte
	localparam int TBL_ENTRY = 3; // bytes per plane entry
	localparam int TBL_SPLASH_OFF = 25; // splash image bytes
	localparam logic [7:0] FLASH_READ_CMD = 8'h03; // flash read opcode
	localparam logic [23:0] FLASH_TBL_ADDR = 24'h000000; // table address
	localparam int FLASH_HDR_BITS = 32; // opcode plus address
	localparam int FLASH_BITS = FLASH_HDR_BITS + TBL_BYTES * 8;
	localparam int SPI_RISE_PH = 4; // phase where sclk goes high
	localparam int SPI_SAMPLE_PH = 7; // phase where miso is taken
	localparam int CLK_NS = 40; // clock period
	localparam int RESET_NS = 200; // least mirror reset pulse time
	localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] LS_CMD_RESET = 8'hA0; // reset command, plane in low bits
	localparam logic [7:0] LFSR_SEED = 8'h01; // dither generator seed
	localparam int FIFO_DEPTH = 4; // capture buffer depth
	// video sources
	typedef enum logic [1:0] {SRC_PAR, SRC_SER, SRC_TEST, SRC_SPLASH} bvs_src_type;
	// sequencer states
	typedef enum logic [2:0] {SQ_BOOT, SQ_IDLE, SQ_LOAD, SQ_RESET, SQ_SHOW} bvs_seq_type;
	// link pins as one bundle
	typedef struct packed {
		logic pclk;
		logic de;
		logic vsync;
		logic [LINK_W-1:0] par;
		logic [LINK_W-1:0] ser;
	} bvs_link_type;
	// pixel word through the buffer
	typedef struct packed {
		logic sof;
		logic [PIX_W-1:0] red;
	} bvs_pix_type;
	// static configuration
	typedef struct packed {
		logic gamma_en;
		logic dither_en;
		logic scale2x;
		logic bin_mode;
		bvs_src_type src;
	} bvs_cfg_type;
endpackage

// File: design/bvs_sequencer.sv
// capture buffer and bitplane sequencer of the micromirror video path
//
// Operation
// - only the 8-bit red component drives intensity
// - parallel input routes any bit to red
// - serial input remaps whole lanes only
// - mux external, test pattern, splash into processing
// - gamma, dither, scale, then format planes
// - data on high and low speed ports, illumination synced
// - one frame latency from input to display
// - sequence table read from flash, used every frame
// - table sets plane count, weights and timing
// - table sets illumination aligned with mirror changes
// - frame split into binary planes sent sequentially
// - constant illumination, weight set by time
// - binary weights double per plane
// - each lower plane shown half as long
// - controller generates the mirror reset waveform
// - reset waveform after each plane load
`timescale 1ns/1ps

// small synchronous fifo, depth a power of two
module bvs_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input logic clk_i,
	input logic rst_i,
	input logic in_valid_i,
	output logic in_ready_o,
	input logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH); // count when full
	// whole fifo state
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} bvs_fifo_st_type;
	bvs_fifo_st_type st_r;
	bvs_fifo_st_type st_nxt;
	logic push; // accepted write
	logic pop; // accepted read

	// honest full and empty flags
	assign in_ready_o = (st_r.cnt != FULL);
	assign out_valid_o = (st_r.cnt != '0);
	assign out_data_o = st_r.mem[st_r.rd];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// next state
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = in_data_i;
			st_nxt.wr = st_r.wr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd = st_r.rd + 1'b1;
		end
		st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// top: capture, processing, frame banks, flash table and sequencer
module bvs_sequencer (
	input logic clk_i,
	input logic rst_i,
	input logic link_pclk_i,
	input logic link_de_i,
	input logic link_vsync_i,
	input logic [23:0] par_data_i,
	input logic [23:0] ser_lanes_i,
	input logic [39:0] par_map_i,
	input logic [7:0] lane_map_i,
	input bvs_pkg::bvs_cfg_type cfg_i,
	input logic spi_miso_i,
	output logic spi_cs_n_o,
	output logic spi_sclk_o,
	output logic spi_mosi_o,
	output logic [3:0] hs_data_o,
	output logic hs_valid_o,
	output logic [7:0] ls_cmd_o,
	output logic ls_valid_o,
	output logic mirror_reset_o,
	output logic illum_o,
	output logic [2:0] plane_o,
	output logic table_ready_o,
	output logic fifo_ovf_o
);
	// whole block state
	typedef struct packed {
		bvs_pkg::bvs_link_type s1; // first sync stage
		bvs_pkg::bvs_link_type s2; // second sync stage
		logic miso1;
		logic miso2;
		logic pclk_d; // for pixel clock edge
		logic vs_d; // for frame start edge
		logic first; // next pixel opens a frame
		logic [3:0] cap_idx; // generated source pixel index
		logic wbank; // bank being written
		logic pend; // new frame waiting for sequencer
		logic p_busy; // processing holds a pixel
		logic p_second; // duplicate write pending
		logic [7:0] p_val; // processed intensity
		logic [3:0] w_idx; // frame bank write index
		logic [1:0][15:0][7:0] fb; // two frame banks
		logic [7:0] lfsr; // dither noise
		logic [8:0] fl_cnt; // flash bit counter
		logic [2:0] fl_ph; // spi bit phase
		logic [7:0] fl_sh; // flash byte shifter
		logic fl_done;
		logic [40:0][7:0] tbl; // sequence table and splash
		logic cs_n;
		logic sclk;
		logic mosi;
		bvs_pkg::bvs_seq_type st;
		logic [2:0] plane;
		logic [1:0] beat; // load beat within a plane
		logic [15:0] tmr; // reset and display timer
		logic [3:0] hs_data;
		logic hs_valid;
		logic [7:0] ls_cmd;
		logic ls_valid;
		logic mreset;
		logic illum;
		logic ovf;
	} bvs_state_type;
	bvs_state_type st_r;
	bvs_state_type st_nxt;

	bvs_pkg::bvs_link_type link_in; // raw link pins
	logic [7:0] par_red; // parallel port after bit mux
	logic [1:0][5:0] lane_w; // remapped logical lanes
	logic [7:0] ser_red; // red from serial lanes
	bvs_pkg::bvs_pix_type cap_pix; // word pushed to fifo
	bvs_pkg::bvs_pix_type proc_pix; // word popped from fifo
	logic push; // pixel taken from link
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [3:0] nplanes; // planes per frame
	logic [15:0] dur0_w; // base display time
	logic [2:0] bitsel; // pixel bit for current plane
	logic exp_bit; // first pixel bit of current beat
	localparam logic [31:0] FLASH_HDR = {bvs_pkg::FLASH_READ_CMD, bvs_pkg::FLASH_TBL_ADDR}; // header, msb first

	assign link_in = {link_pclk_i, link_de_i, link_vsync_i, par_data_i, ser_lanes_i};

	// parallel bit mux: any input bit onto any red bit
	for (genvar b = 0; b < 8; b++) begin : g_pmux
		logic [4:0] sel;
		assign sel = par_map_i[b*bvs_pkg::PMAP_W +: bvs_pkg::PMAP_W];
		assign par_red[b] = (sel < 5'd24) ? st_r.s2.par[sel] : 1'b0;
	end

	// serial lane remap: whole lanes only, fixed bit order inside
	for (genvar l = 0; l < bvs_pkg::RED_LANES; l++) begin : g_lane
		assign lane_w[l] = st_r.s2.ser[lane_map_i[l*2 +: 2]*bvs_pkg::LANE_W +: bvs_pkg::LANE_W];
	end
	assign ser_red = {lane_w[1][1:0], lane_w[0][5:0]};

	// plane count clamped to 1..8, base time and bit selection
	assign nplanes = (st_r.tbl[0][3:0] == 4'h0) ? 4'h1 :
		(st_r.tbl[0][3:0] > 4'h8) ? 4'h8 : st_r.tbl[0][3:0];
	assign dur0_w = {st_r.tbl[bvs_pkg::TBL_PLANE_OFF], st_r.tbl[bvs_pkg::TBL_PLANE_OFF+1]};
	assign bitsel = 3'(4'(st_r.plane) + 4'h8 - nplanes);
	assign exp_bit = st_r.fb[~st_r.wbank][{st_r.beat, 2'b00}][bitsel];

	// capture buffer between link and processing
	bvs_fifo #(
		.WIDTH($bits(bvs_pkg::bvs_pix_type)),
		.DEPTH(bvs_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(cap_pix),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~st_r.p_busy),
		.out_data_o(proc_pix)
	);

	// all next-state logic
	always_comb begin
		logic pclk_rise;
		logic vs_rise;
		logic [15:0] sq;
		logic [7:0] g;
		logic [8:0] sum;
		logic [5:0] bidx;
		logic [5:0] pe;
		logic [15:0] dur;
		logic [7:0] mask;
		pclk_rise = 1'b0;
		vs_rise = 1'b0;
		sq = '0;
		g = '0;
		sum = '0;
		bidx = '0;
		pe = '0;
		dur = '0;
		mask = '0;
		st_nxt = st_r;
		// two-stage synchronisers for link and flash input
		st_nxt.s1 = link_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.miso1 = spi_miso_i;
		st_nxt.miso2 = st_r.miso1;
		st_nxt.pclk_d = st_r.s2.pclk;
		st_nxt.vs_d = st_r.s2.vsync;
		pclk_rise = st_r.s2.pclk & ~st_r.pclk_d;
		vs_rise = st_r.s2.vsync & ~st_r.vs_d;
		st_nxt.lfsr = {st_r.lfsr[6:0], st_r.lfsr[7] ^ st_r.lfsr[5] ^ st_r.lfsr[4] ^ st_r.lfsr[3]};

		// source mux, blue and green never reach the path
		cap_pix.sof = st_r.first;
		case (cfg_i.src)
			bvs_pkg::SRC_PAR: cap_pix.red = par_red;
			bvs_pkg::SRC_SER: cap_pix.red = ser_red;
			bvs_pkg::SRC_TEST: cap_pix.red = {st_r.cap_idx, st_r.cap_idx}; // ramp
			bvs_pkg::SRC_SPLASH: cap_pix.red = st_r.tbl[6'(bvs_pkg::TBL_SPLASH_OFF) + {2'b00, st_r.cap_idx}];
			default: cap_pix.red = '0;
		endcase
		push = pclk_rise & st_r.s2.de;
		if (push) begin
			st_nxt.cap_idx = st_r.cap_idx + 4'h1;
			st_nxt.first = 1'b0;
			if (!fifo_in_ready) begin
				st_nxt.ovf = 1'b1; // link cannot stall: report loss
			end
		end
		// frame boundary: swap banks so display lags input one frame
		if (vs_rise) begin
			st_nxt.cap_idx = '0;
			st_nxt.first = 1'b1;
			st_nxt.wbank = ~st_r.wbank;
			st_nxt.pend = st_r.fl_done;
		end

		// processing: gamma, dither to plane depth, optional 2x width
		mask = 8'hFF >> nplanes;
		if (!st_r.p_busy && fifo_out_valid) begin
			sq = 16'(proc_pix.red) * 16'(proc_pix.red);
			g = cfg_i.gamma_en ? sq[15:8] : proc_pix.red;
			sum = {1'b0, g} + {1'b0, st_r.lfsr & mask};
			st_nxt.p_val = !cfg_i.dither_en ? g : (sum[8] ? 8'hFF : sum[7:0]);
			st_nxt.p_busy = 1'b1;
			st_nxt.p_second = 1'b0;
			if (proc_pix.sof) begin
				st_nxt.w_idx = '0;
			end
		end else if (st_r.p_busy) begin
			st_nxt.fb[st_r.wbank][st_r.w_idx] = st_r.p_val;
			st_nxt.w_idx = st_r.w_idx + 4'h1;
			if (cfg_i.scale2x && !st_r.p_second) begin
				st_nxt.p_second = 1'b1; // stall fifo for duplicate
			end else begin
				st_nxt.p_busy = 1'b0;
			end
		end

		// flash reader: opcode and address out, table bytes in
		if (!st_r.fl_done) begin
			st_nxt.cs_n = 1'b0;
			st_nxt.fl_ph = st_r.fl_ph + 3'h1;
			st_nxt.sclk = (st_nxt.fl_ph >= 3'(bvs_pkg::SPI_RISE_PH));
			if (st_r.fl_ph == 3'h0) begin
				st_nxt.mosi = (st_r.fl_cnt < 9'(bvs_pkg::FLASH_HDR_BITS)) ?
					FLASH_HDR[5'(31 - st_r.fl_cnt)] : 1'b0;
			end
			if (st_r.fl_ph == 3'(bvs_pkg::SPI_SAMPLE_PH)) begin
				st_nxt.fl_cnt = st_r.fl_cnt + 9'h1;
				if (st_r.fl_cnt >= 9'(bvs_pkg::FLASH_HDR_BITS)) begin
					st_nxt.fl_sh = {st_r.fl_sh[6:0], st_r.miso2};
					bidx = 6'((st_r.fl_cnt - 9'(bvs_pkg::FLASH_HDR_BITS)) >> 3);
					if (st_r.fl_cnt[2:0] == 3'h7) begin
						st_nxt.tbl[bidx] = {st_r.fl_sh[6:0], st_r.miso2};
					end
				end
				if (st_r.fl_cnt == 9'(bvs_pkg::FLASH_BITS - 1)) begin
					st_nxt.fl_done = 1'b1;
					st_nxt.cs_n = 1'b1;
					st_nxt.sclk = 1'b0;
					st_nxt.mosi = 1'b0;
				end
			end
		end

		// sequencer: load plane, reset mirrors, show for its time
		pe = 6'(bvs_pkg::TBL_PLANE_OFF) + 6'(st_r.plane) * 6'(bvs_pkg::TBL_ENTRY);
		dur = cfg_i.bin_mode ? (dur0_w << st_r.plane) : {st_r.tbl[pe], st_r.tbl[pe+6'h1]};
		st_nxt.hs_valid = 1'b0;
		st_nxt.ls_valid = 1'b0;
		case (st_r.st)
			bvs_pkg::SQ_BOOT: begin
				if (st_r.fl_done) begin
					st_nxt.st = bvs_pkg::SQ_IDLE;
				end
			end
			bvs_pkg::SQ_IDLE: begin
				st_nxt.illum = 1'b0;
			end
			bvs_pkg::SQ_LOAD: begin
				// one bit of each pixel, sent four pixels a beat
				for (int k = 0; k < bvs_pkg::HS_W; k++) begin
					st_nxt.hs_data[k] = st_r.fb[~st_r.wbank][{st_r.beat, 2'(k)}][bitsel];
				end
				st_nxt.hs_valid = 1'b1;
				st_nxt.beat = st_r.beat + 2'h1;
				if (st_r.beat == 2'(bvs_pkg::LOAD_BEATS - 1)) begin
					st_nxt.st = bvs_pkg::SQ_RESET;
					st_nxt.tmr = 16'(bvs_pkg::RESET_CYC);
				end
			end
			bvs_pkg::SQ_RESET: begin
				if (!st_r.mreset) begin
					// last beat is out: reset fires the cycle after, never during a load
					st_nxt.ls_cmd = bvs_pkg::LS_CMD_RESET | {5'h00, st_r.plane};
					st_nxt.ls_valid = 1'b1;
					st_nxt.mreset = 1'b1;
				end else begin
					st_nxt.tmr = st_r.tmr - 16'h1;
					if (st_r.tmr <= 16'h1) begin
						st_nxt.mreset = 1'b0;
						st_nxt.st = bvs_pkg::SQ_SHOW;
						st_nxt.tmr = dur;
						st_nxt.illum = st_r.tbl[pe+6'h2][0];
					end
				end
			end
			bvs_pkg::SQ_SHOW: begin
				st_nxt.tmr = st_r.tmr - 16'h1;
				if (st_r.tmr <= 16'h1) begin
					st_nxt.illum = 1'b0;
					st_nxt.beat = '0;
					if (4'(st_r.plane) + 4'h1 < nplanes) begin
						st_nxt.plane = st_r.plane + 3'h1;
						st_nxt.st = bvs_pkg::SQ_LOAD;
					end else begin
						st_nxt.st = bvs_pkg::SQ_IDLE;
					end
				end
			end
			default: st_nxt.st = bvs_pkg::SQ_BOOT;
		endcase
		// new frame taken when idle or during a plane's show time, never mid load or reset
		if (st_r.pend && (st_r.st == bvs_pkg::SQ_IDLE || st_r.st == bvs_pkg::SQ_SHOW)) begin
			st_nxt.pend = vs_rise & st_r.fl_done;
			st_nxt.st = bvs_pkg::SQ_LOAD;
			st_nxt.plane = '0;
			st_nxt.beat = '0;
			st_nxt.illum = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.cs_n <= 1'b1;
			st_r.first <= 1'b1;
			st_r.lfsr <= bvs_pkg::LFSR_SEED;
			st_r.st <= bvs_pkg::SQ_BOOT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from state
	assign spi_cs_n_o = st_r.cs_n;
	assign spi_sclk_o = st_r.sclk;
	assign spi_mosi_o = st_r.mosi;
	assign hs_data_o = st_r.hs_data;
	assign hs_valid_o = st_r.hs_valid;
	assign ls_cmd_o = st_r.ls_cmd;
	assign ls_valid_o = st_r.ls_valid;
	assign mirror_reset_o = st_r.mreset;
	assign illum_o = st_r.illum;
	assign plane_o = st_r.plane;
	assign table_ready_o = st_r.fl_done;
	assign fifo_ovf_o = st_r.ovf;

	// checks on the sequencer and processing
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_load4;
		hs_valid_o [*4];
	endsequence
	sequence s_reset5;
		mirror_reset_o [*5] ##1 !mirror_reset_o;
	endsequence
	load_then_reset_a: assert property ($rose(hs_valid_o) |-> s_load4 ##1 (ls_valid_o && mirror_reset_o))
		else $error("plane load not followed by reset command");
	reset_width_a: assert property ($rose(mirror_reset_o) |-> s_reset5)
		else $error("mirror reset pulse has wrong width");
	dark_reset_a: assert property (mirror_reset_o |-> !illum_o && !hs_valid_o)
		else $error("light or load during mirror reset");
	load_hold_a: assert property (hs_valid_o |-> !illum_o ##0 !$rose(mirror_reset_o))
		else $error("display changed during plane load");
	bin_time_a: assert property ((st_r.st == bvs_pkg::SQ_RESET && st_r.tmr == 16'h1 && cfg_i.bin_mode)
		|=> st_r.tmr == (dur0_w << st_r.plane))
		else $error("binary plane time not doubled");
	plane_bit_a: assert property ((st_r.st == bvs_pkg::SQ_LOAD)
		|=> hs_data_o[0] == $past(exp_bit))
		else $error("plane bit differs from pixel bit");
	plane_limit_a: assert property (hs_valid_o |-> 4'(plane_o) < nplanes)
		else $error("plane beyond table count");
	proc_stall_a: assert property ((st_r.p_busy && fifo_out_valid) |=> $stable(proc_pix))
		else $error("fifo drained while processing busy");
	frame_start_a: assert property ((st_r.pend && st_r.st == bvs_pkg::SQ_IDLE)
		|-> ##2 ($rose(hs_valid_o) && plane_o == 3'h0))
		else $error("frame not started from plane zero");
endmodule

// File: testbench/bitplane_video_sequencer_test.sv
// self-checking bench of the bitplane video sequencer
`timescale 1ns/1ps
module bitplane_video_sequencer_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [39:0] par_map_i;
	logic [7:0] lane_map_i;
	bvs_pkg::bvs_cfg_type cfg_i;
	bvs_pkg::bvs_link_type link; // link pins from the source model
	logic spi_miso, spi_cs_n, spi_sclk, spi_mosi;
	logic [3:0] hs_data_o;
	logic [7:0] ls_cmd_o;
	logic [2:0] plane_o;
	logic hs_valid_o, ls_valid_o, mirror_reset_o, illum_o, table_ready_o, fifo_ovf_o;
	int n_fail = 0;
	int n_checks = 0;
	int cs_low = 0; // cycles with flash selected
	logic [7:0] expv [16]; // intensity expected on display
	logic [23:0] word [16]; // words sent in the next frame
	// clock, 40 ns period
	always #20 clk_i = ~clk_i;
	bvs_partner partner_u (.spi_cs_n_i(spi_cs_n), .spi_sclk_i(spi_sclk), .spi_mosi_i(spi_mosi),
		.spi_miso_o(spi_miso), .link_o(link));
	bvs_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .link_pclk_i(link.pclk), .link_de_i(link.de),
		.link_vsync_i(link.vsync), .par_data_i(link.par), .ser_lanes_i(link.ser), .par_map_i(par_map_i),
		.lane_map_i(lane_map_i), .cfg_i(cfg_i), .spi_miso_i(spi_miso), .spi_cs_n_o(spi_cs_n),
		.spi_sclk_o(spi_sclk), .spi_mosi_o(spi_mosi), .hs_data_o(hs_data_o), .hs_valid_o(hs_valid_o),
		.ls_cmd_o(ls_cmd_o), .ls_valid_o(ls_valid_o), .mirror_reset_o(mirror_reset_o), .illum_o(illum_o),
		.plane_o(plane_o), .table_ready_o(table_ready_o), .fifo_ovf_o(fifo_ovf_o));
	// count cycles in which the flash is selected
	always @(posedge clk_i) begin
		if (!rst_i && spi_cs_n === 1'b0)
			cs_low++;
	end
	// one edge, then settle
	task automatic tick;
		@(posedge clk_i);
		#1;
	endtask
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// follow the four planes shown after a vsync
	task automatic watch(input bit chk);
		logic [15:0] bits;
		logic [15:0] want;
		int n;
		// level wait: the source may raise vsync in this very time step
		wait (link.vsync === 1'b1);
		for (int p = 0; p < 4; p++) begin
			n = 0;
			while (hs_valid_o !== 1'b1 && n < 300) begin
				tick;
				n++;
			end
			check(n < 300, 1);
			for (int b = 0; b < 4; b++) begin
				bits[4 * b +: 4] = hs_data_o;
				tick;
			end
			// load ends, command and reset start together, light off
			check({hs_valid_o, ls_valid_o, mirror_reset_o, illum_o, ls_cmd_o},
				{4'b0110, bvs_pkg::LS_CMD_RESET | 8'(p)});
			n = 0;
			while (mirror_reset_o === 1'b1 && n < 50) begin
				tick;
				n++;
			end
			check(n, bvs_pkg::RESET_CYC);
			check(plane_o, p);
			n = 0;
			while (illum_o === 1'b1 && n < 300) begin
				tick;
				n++;
			end
			check(n, (p == 2) ? 0 : (cfg_i.bin_mode ? 8 << p : 8));
			for (int k = 0; k < 16; k++) begin
				want[k] = expv[k][p + 4];
			end
			if (chk)
				check(bits, want);
		end
	endtask
	// send one frame while watching the display of the previous one
	task automatic frame(input bit chk);
		fork
			partner_u.send_frame(word);
			watch(chk);
		join
		repeat (20) tick;
	endtask
	// table read from flash after reset
	task automatic t_flash;
		int n = 0;
		while (table_ready_o !== 1'b1 && n < 4000) begin
			tick;
			n++;
		end
		check(partner_u.cmd_r, {bvs_pkg::FLASH_READ_CMD, bvs_pkg::FLASH_TBL_ADDR});
		// select drops one edge after release, so bit 0 is one cycle short
		check(cs_low, bvs_pkg::FLASH_BITS * 8 - 1);
		check(spi_cs_n, 1'b1);
		$display("test flash done");
	endtask
	// parallel input, red routed from reversed top bits, green and blue busy
	task automatic t_parallel(input bit gam);
		logic [7:0] r;
		cfg_i.gamma_en = gam;
		// dither noise must stay below the four shown bits
		cfg_i.dither_en = ~gam;
		for (int i = 0; i < 16; i++) begin
			r = gam ? {~i[3:0], 4'h9} : {i[3:0], 4'h0};
			expv[i] = gam ? 8'((int'(r) * int'(r)) >> 8) : r;
			word[i] = {8'h00, 8'hA5, 8'h5A};
			for (int b = 0; b < 8; b++) begin
				word[i][23 - b] = r[b];
			end
		end
		frame(0);
		frame(1);
		cfg_i.gamma_en = 1'b0;
		cfg_i.dither_en = 1'b0;
		$display("test parallel done");
	endtask
	// serial input with lanes 0 and 1 swapped, horizontal doubling
	task automatic t_serial;
		logic [7:0] r;
		cfg_i.src = bvs_pkg::SRC_SER;
		cfg_i.scale2x = 1'b1;
		lane_map_i = 8'hE1;
		for (int i = 0; i < 16; i++) begin
			r = {i[3:0], 4'h3};
			word[i] = {12'h000, r[5:0], 4'h0, r[7:6]};
			expv[i] = {4'(8 + i / 2), 4'h3};
		end
		frame(0);
		frame(1);
		cfg_i.scale2x = 1'b0;
		$display("test serial done");
	endtask
	// splash image from flash, then the test pattern source
	task automatic t_sources;
		cfg_i.src = bvs_pkg::SRC_SPLASH;
		for (int i = 0; i < 16; i++) begin
			expv[i] = partner_u.tbl[bvs_pkg::TBL_SPLASH_OFF + i];
		end
		frame(0);
		frame(1);
		// test ramp, plane times taken from the table entries
		cfg_i.src = bvs_pkg::SRC_TEST;
		cfg_i.bin_mode = 1'b0;
		for (int i = 0; i < 16; i++) begin
			expv[i] = {i[3:0], i[3:0]};
		end
		frame(0);
		frame(1);
		cfg_i.bin_mode = 1'b1;
		check(fifo_ovf_o, 1'b0);
		$display("test sources done");
	endtask
	// closing report
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		$display("unexpected at %0t: got %h want %h", $time, 0, 1);
		summarize;
	end
	// main sequence
	initial begin
		cfg_i = '0;
		cfg_i.bin_mode = 1'b1;
		lane_map_i = 8'hE4;
		for (int b = 0; b < 8; b++) begin
			par_map_i[5 * b +: 5] = 5'(23 - b);
		end
		for (int i = 0; i < 16; i++) begin
			word[i] = 24'h000000;
		end
		repeat (16) tick;
		rst_i = 1'b0;
		t_flash;
		t_parallel(0);
		t_parallel(1);
		t_serial;
		t_sources;
		summarize;
	end
endmodule

// File: testbench/bvs_partner.sv
// far-side model: video source on the link and the sequence table flash
`timescale 1ns/1ps
module bvs_partner (
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	output bvs_pkg::bvs_link_type link_o
);
	logic [7:0] tbl [bvs_pkg::TBL_BYTES]; // table served on read
	logic [31:0] cmd_r; // opcode and address shifted in
	int rises; // sclk rises seen so far
	// table: 4 planes, base time 8, plane 2 kept dark, splash pattern
	initial begin
		for (int i = 0; i < bvs_pkg::TBL_BYTES; i++) begin
			tbl[i] = 8'h00;
		end
		tbl[0] = 8'h04;
		for (int p = 0; p < 4; p++) begin
			tbl[2 + 3 * p] = 8'h08;
			tbl[3 + 3 * p] = (p == 2) ? 8'h00 : 8'h01;
		end
		for (int i = 0; i < 16; i++) begin
			tbl[bvs_pkg::TBL_SPLASH_OFF + i] = {i[3:0], ~i[3:0]};
		end
		link_o = '0;
		spi_miso_o = 1'b1;
		cmd_r = '0;
		rises = 0;
	end
	// command bits taken on the rising sclk edge
	always @(posedge spi_sclk_i) begin
		if (!spi_cs_n_i) begin
			if (rises < 32)
				cmd_r <= {cmd_r[30:0], spi_mosi_i};
			rises <= rises + 1;
		end
	end
	// data shifted out MSB first on the falling edge; released line flips
	always @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i)
			spi_miso_o <= ~spi_miso_o;
		else if (rises >= 32 && rises < bvs_pkg::FLASH_BITS)
			spi_miso_o <= tbl[(rises - 32) / 8][7 - (rises - 32) % 8];
	end
	// one frame: vsync for two pclk periods, 16 pixels, pclk still afterwards
	task automatic send_frame(input logic [23:0] w [16]);
		for (int k = 0; k < 19; k++) begin
			link_o.vsync = (k < 2);
			link_o.de = (k >= 2 && k < 18);
			// all lanes carry the word; idle data toggles
			link_o.par = link_o.de ? w[k - 2] : ~link_o.par;
			link_o.ser = link_o.de ? w[k - 2] : ~link_o.ser;
			#160 link_o.pclk = 1'b1;
			#160 link_o.pclk = 1'b0;
		end
	endtask
endmodule
